//--- alcs_defs.vh
`ifndef ALCS_DEFS_VH
`define ALCS_DEFS_VH
// ************************************************************
// frame framing bytes
// ************************************************************
`define ALCS_START 8'h7e
`define ALCS_ESC 8'h7d
`define ALCS_ESC_XOR 8'h20
`define ALCS_XON 8'h11
`define ALCS_XOFF 8'h13
`define ALCS_CSUM_BASE 8'hff
// ************************************************************
// frame types
// ************************************************************
`define ALCS_T_STATUS 8'h8a
`define ALCS_T_CMD 8'h08
`define ALCS_T_QUEUE 8'h09
`define ALCS_T_RESP 8'h88
// ************************************************************
// status event codes
// ************************************************************
`define ALCS_EV_HW_RESET 8'h00
`define ALCS_EV_WDOG_RESET 8'h01
`define ALCS_EV_ASSOC 8'h02
`define ALCS_EV_DISASSOC 8'h03
`define ALCS_EV_FORMED 8'h06
`define ALCS_EV_OVERVOLT 8'h0d
// ************************************************************
// response status codes
// ************************************************************
`define ALCS_RS_OK 8'h00
`define ALCS_RS_ERROR 8'h01
`define ALCS_RS_BAD_CMD 8'h02
`define ALCS_RS_BAD_PARAM 8'h03
// ************************************************************
// frame data offsets and limits
// ************************************************************
`define ALCS_OFS_ID 8'h01
`define ALCS_OFS_NAME_HI 8'h02
`define ALCS_OFS_NAME_LO 8'h03
`define ALCS_OFS_VALUE 8'h04
`define ALCS_VAL_MAX 8'h04
`define ALCS_DATA_MAX 8'h10
`endif

//--- alcs_tx.v
`timescale 1ns/1ns
`include "alcs_defs.vh"
// ************************************************************
// serialiser: header, escaping and checksum for outbound frames
// ************************************************************
module alcs_tx (
  input wire clock,
  input wire arst_n,
  input wire escaped_mode,
  input wire start,
  input wire [7:0] frame_len,
  input wire [127:0] frame_bytes,
  output wire busy,
  output reg [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready
);
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_LEN_HI = 3'd2;
  localparam S_LEN_LO = 3'd3;
  localparam S_DATA = 3'd4;
  localparam S_CSUM = 3'd5;
  localparam S_ESC2 = 3'd6;
  reg [2:0] state;
  reg [2:0] resume;
  reg [7:0] idx;
  reg [7:0] sum;
  reg [7:0] held;
  reg [7:0] len;
  reg [127:0] buf_bytes;
  reg valid;
  reg [7:0] pick;
  wire [7:0] cur_byte;
  wire [7:0] csum;
  assign busy = (state != S_IDLE);
  assign tx_valid = valid;
  assign cur_byte = buf_bytes[idx[3:0]*8 +: 8];
  assign csum = `ALCS_CSUM_BASE - sum; // RL17
  // byte that the current state sends next, before any escaping
  always @* begin
    case (state)
      S_LEN_HI: pick = 8'h00;
      S_LEN_LO: pick = len;
      S_DATA: pick = cur_byte;
      S_CSUM: pick = csum;
      default: pick = 8'h00;
    endcase
  end
  // bytes that collide with framing must be escaped after the start
  function needs_esc;
    input [7:0] b;
    begin
      needs_esc = (b == `ALCS_START) || (b == `ALCS_ESC) || (b == `ALCS_XON) || (b == `ALCS_XOFF);
    end
  endfunction
  // sends one byte each accepted beat; escape state is inserted as needed
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      resume <= S_IDLE;
      idx <= 8'h00;
      sum <= 8'h00;
      held <= 8'h00;
      len <= 8'h00;
      buf_bytes <= 128'h0;
      valid <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            buf_bytes <= frame_bytes;
            len <= frame_len;
            idx <= 8'h00;
            sum <= 8'h00;
            tx_data <= `ALCS_START; // RL16
            valid <= 1'b1;
            state <= S_LEN_HI;
          end
        end
        S_START, S_LEN_HI, S_LEN_LO, S_DATA, S_CSUM: begin
          if (tx_ready) begin
            // length is unescaped count, high byte first; held keeps the byte for the escape beat
            held <= pick;
            if (state == S_LEN_HI) begin
              resume <= S_LEN_LO;
            end else if (state == S_LEN_LO) begin
              resume <= S_DATA;
            end else if (state == S_DATA) begin
              sum <= sum + cur_byte;
              idx <= idx + 8'h01;
              resume <= (idx + 8'h01 == len) ? S_CSUM : S_DATA;
            end else if (state == S_CSUM) begin
              resume <= S_START;
            end
            if (state == S_START) begin
              valid <= 1'b0;
              state <= S_IDLE;
            end else if (escaped_mode && needs_esc(pick)) begin
              tx_data <= `ALCS_ESC; // RL19
              state <= S_ESC2;
            end else begin
              tx_data <= pick;
              state <= (state == S_LEN_HI) ? S_LEN_LO : (state == S_LEN_LO) ? S_DATA :
                       (state == S_DATA) ? ((idx + 8'h01 == len) ? S_CSUM : S_DATA) : S_START;
            end
          end
        end
        S_ESC2: begin
          if (tx_ready) begin
            tx_data <= held ^ `ALCS_ESC_XOR; // RL19
            state <= resume;
          end
        end
        default: begin
          state <= S_IDLE;
          valid <= 1'b0;
        end
      endcase
    end
  end
endmodule

//--- alcs_core.v
`timescale 1ns/1ns
`include "alcs_defs.vh"
// Summary of operation
// RL1: status frames type 0x8a, code at offset 1
// RL2: status codes for reset, network, overvoltage events
// RL3: power-up sends hardware reset status, checksum 0x75
// RL4: command: type, id, two-byte name, optional value
// RL5: type 0x08 value write applies immediately
// RL6: no value after name means a read
// RL7: reads answered with 0x88 and copied id
// RL8: frame id zero executes without response
// RL9: type 0x09 writes only stage, applied later
// RL10: type 0x09 reads answered immediately like 0x08
// RL11: host sends binary values, padded 2 or 4
// RL12: response: id, name, status, optional data
// RL13: status 0 ok, 1 error, 2 name, 3 value
// RL14: writes return no data, reads return binary
// RL15: multi-response sequences end with empty ok
// RL16: frames start 0x7e, big-endian data length
// RL17: checksum is 0xff minus data byte sum
// RL18: bad-checksum frames are dropped silently
// RL19: escaped mode: 0x7d then byte xor 0x20
module alcs_core (
  input wire clock,
  input wire arst_n,
  input wire escaped_mode,
  input wire [7:0] rx_data,
  input wire rx_valid,
  output wire rx_ready,
  output wire [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready,
  input wire watchdog_reset_seen,
  input wire event_valid,
  input wire [7:0] event_code,
  output wire event_ready,
  output reg cmd_valid,
  output reg cmd_write,
  output reg cmd_stage,
  output reg [15:0] cmd_name,
  output reg [31:0] cmd_value,
  output reg [7:0] cmd_value_len,
  input wire cmd_done,
  input wire [7:0] cmd_status,
  input wire [31:0] cmd_rdata,
  input wire [7:0] cmd_rdata_len,
  input wire cmd_more
);
  // ************************************************************
  // receive parser
  // ************************************************************
  localparam R_HUNT = 3'd0;
  localparam R_LEN_HI = 3'd1;
  localparam R_LEN_LO = 3'd2;
  localparam R_DATA = 3'd3;
  localparam R_CSUM = 3'd4;
  localparam M_BOOT = 2'd0;
  localparam M_IDLE = 2'd1;
  localparam M_EXEC = 2'd2;
  localparam M_SEND = 2'd3;
  reg [2:0] rstate;
  reg esc_pending;
  reg [15:0] rlen;
  reg [15:0] rcount;
  reg [7:0] rsum;
  reg [7:0] rtype;
  reg [7:0] rid;
  reg [15:0] rname;
  reg [31:0] rvalue;
  reg [7:0] rvlen;
  reg frame_ok;
  reg [1:0] mstate;
  reg [7:0] pend_id;
  reg tx_start;
  reg [7:0] tx_len;
  reg [127:0] tx_bytes;
  wire tx_busy;
  wire byte_in;
  wire [7:0] plain;
  // parser stalls while a command is in flight so no frame is lost
  assign rx_ready = (mstate == M_IDLE) && !frame_ok;
  assign byte_in = rx_valid && rx_ready;
  assign plain = esc_pending ? (rx_data ^ `ALCS_ESC_XOR) : rx_data; // RL19
  assign event_ready = (mstate == M_IDLE) && !frame_ok && !tx_busy && !byte_in;
  // collects one frame; a start byte anywhere begins a new frame at the length bytes
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstate <= R_HUNT;
      esc_pending <= 1'b0;
      rlen <= 16'h0000;
      rcount <= 16'h0000;
      rsum <= 8'h00;
      rtype <= 8'h00;
      rid <= 8'h00;
      rname <= 16'h0000;
      rvalue <= 32'h0;
      rvlen <= 8'h00;
      frame_ok <= 1'b0;
    end else begin
      if (mstate == M_EXEC) begin
        frame_ok <= 1'b0;
      end
      if (byte_in) begin
        if (rx_data == `ALCS_START) begin
          rstate <= R_LEN_HI; // RL16
          esc_pending <= 1'b0;
        end else if (escaped_mode && !esc_pending && rx_data == `ALCS_ESC) begin
          esc_pending <= 1'b1;
        end else begin
          esc_pending <= 1'b0;
          case (rstate)
            R_HUNT: rstate <= R_HUNT;
            R_LEN_HI: begin
              rlen[15:8] <= plain;
              rstate <= R_LEN_LO;
            end
            R_LEN_LO: begin
              rlen[7:0] <= plain;
              rcount <= 16'h0000;
              rsum <= 8'h00;
              rvalue <= 32'h0;
              rvlen <= 8'h00;
              rstate <= ({rlen[15:8], plain} == 16'h0000) ? R_HUNT : R_DATA;
            end
            R_DATA: begin
              rsum <= rsum + plain;
              rcount <= rcount + 16'h0001;
              if (rcount == 16'h0000) rtype <= plain;
              if (rcount[7:0] == `ALCS_OFS_ID && rcount[15:8] == 8'h00) rid <= plain; // RL4
              if (rcount[7:0] == `ALCS_OFS_NAME_HI && rcount[15:8] == 8'h00) rname[15:8] <= plain;
              if (rcount[7:0] == `ALCS_OFS_NAME_LO && rcount[15:8] == 8'h00) rname[7:0] <= plain;
              if (rcount >= {8'h00, `ALCS_OFS_VALUE}) begin
                // binary value, big-endian; zero padding is harmless
                rvalue <= {rvalue[23:0], plain}; // RL11
                rvlen <= rvlen + 8'h01;
              end
              if (rcount + 16'h0001 == rlen) rstate <= R_CSUM;
            end
            R_CSUM: begin
              // sum of data plus checksum must come to 0xff, else drop
              frame_ok <= ((rsum + plain) == `ALCS_CSUM_BASE) && (rcount >= {8'h00, `ALCS_OFS_VALUE}) &&
                          (rtype == `ALCS_T_CMD || rtype == `ALCS_T_QUEUE); // RL18
              rstate <= R_HUNT;
            end
            default: rstate <= R_HUNT;
          endcase
        end
      end
    end
  end
  // ************************************************************
  // command sequencer and response builder
  // ************************************************************
  // packs a response frame into the serialiser image
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mstate <= M_BOOT;
      pend_id <= 8'h00;
      tx_start <= 1'b0;
      tx_len <= 8'h00;
      tx_bytes <= 128'h0;
      cmd_valid <= 1'b0;
      cmd_write <= 1'b0;
      cmd_stage <= 1'b0;
      cmd_name <= 16'h0000;
      cmd_value <= 32'h0;
      cmd_value_len <= 8'h00;
    end else begin
      tx_start <= 1'b0;
      case (mstate)
        M_BOOT: begin
          // first frame after reset reports why the device restarted
          if (!tx_busy) begin
            tx_bytes <= 128'h0;
            tx_bytes[7:0] <= `ALCS_T_STATUS; // RL1
            tx_bytes[15:8] <= watchdog_reset_seen ? `ALCS_EV_WDOG_RESET : `ALCS_EV_HW_RESET; // RL3
            tx_len <= 8'h02;
            tx_start <= 1'b1;
            mstate <= M_SEND;
          end
        end
        M_IDLE: begin
          if (frame_ok) begin
            // a value means write; 0x08 applies, 0x09 only queues
            cmd_valid <= 1'b1;
            cmd_write <= (rvlen != 8'h00); // RL6
            cmd_stage <= (rvlen != 8'h00) && (rtype == `ALCS_T_QUEUE); // RL9 RL10
            cmd_name <= rname;
            cmd_value <= rvalue;
            cmd_value_len <= rvlen; // RL5
            pend_id <= rid;
            mstate <= M_EXEC;
          end else if (event_valid && event_ready) begin
            tx_bytes <= 128'h0;
            tx_bytes[7:0] <= `ALCS_T_STATUS; // RL1
            tx_bytes[15:8] <= event_code; // RL2
            tx_len <= 8'h02;
            tx_start <= 1'b1;
            mstate <= M_SEND;
          end
        end
        M_EXEC: begin
          if (cmd_done && !tx_busy && !tx_start) begin
            if (!cmd_more) cmd_valid <= 1'b0;
            tx_bytes <= 128'h0;
            tx_bytes[7:0] <= `ALCS_T_RESP; // RL7
            tx_bytes[15:8] <= pend_id; // RL7 RL12
            tx_bytes[31:16] <= {cmd_name[7:0], cmd_name[15:8]};
            tx_bytes[39:32] <= cmd_status; // RL13
            // data only on reads; final empty ok ends multi-answer reads
            if (!cmd_write && cmd_rdata_len != 8'h00) begin
              // read data is right-justified, so the first byte sent depends on the length
              case (cmd_rdata_len)
                8'h01: tx_bytes[47:40] <= cmd_rdata[7:0];
                8'h02: tx_bytes[55:40] <= {cmd_rdata[7:0], cmd_rdata[15:8]};
                8'h03: tx_bytes[63:40] <= {cmd_rdata[7:0], cmd_rdata[15:8], cmd_rdata[23:16]};
                default: tx_bytes[71:40] <= {cmd_rdata[7:0], cmd_rdata[15:8], cmd_rdata[23:16], cmd_rdata[31:24]};
              endcase
              tx_len <= 8'h05 + cmd_rdata_len; // RL14
            end else begin
              tx_len <= 8'h05; // RL14 RL15
            end
            tx_start <= (pend_id != 8'h00); // RL8
            if (!cmd_more) mstate <= M_SEND;
          end
        end
        M_SEND: begin
          if (!tx_busy && !tx_start) mstate <= M_IDLE;
        end
        default: mstate <= M_IDLE;
      endcase
    end
  end
  // ************************************************************
  // outbound serialiser
  // ************************************************************
  alcs_tx u_tx (
    .clock(clock),
    .arst_n(arst_n),
    .escaped_mode(escaped_mode),
    .start(tx_start),
    .frame_len(tx_len),
    .frame_bytes(tx_bytes),
    .busy(tx_busy),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );
endmodule

//--- alcs_core_chk.sv
`timescale 1ns/1ns
// ********************
// checker on the core ports
// ********************
module alcs_core_chk (
  input logic clock,
  input logic arst_n,
  input logic escaped_mode,
  input logic rx_ready,
  input logic [7:0] tx_data,
  input logic tx_valid,
  input logic tx_ready,
  input logic event_ready,
  input logic cmd_valid,
  input logic cmd_write,
  input logic cmd_stage,
  input logic [15:0] cmd_name,
  input logic [31:0] cmd_value,
  input logic [7:0] cmd_value_len,
  input logic cmd_done,
  input logic cmd_more
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!arst_n);
  // boot frame goes out first, parser stays shut meanwhile
  a_boot_start: assert property ($rose(arst_n) |-> ##[0:4] (tx_valid && tx_data == 8'h7e))
    else $error("boot frame start missing");
  a_boot_shut: assert property ($rose(arst_n) |-> !rx_ready [*4])
    else $error("parser open during boot frame");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed while stalled");
  a_cmd_hold: assert property (cmd_valid && !cmd_done |=>
    cmd_valid && $stable({cmd_write, cmd_stage, cmd_name, cmd_value}))
    else $error("command changed before done");
  a_cmd_release: assert property (cmd_valid && cmd_done && !cmd_more |-> ##[1:2] !cmd_valid)
    else $error("command not released");
  a_stage_write: assert property (cmd_valid && cmd_stage |-> cmd_write)
    else $error("staged command without value");
  a_read_len: assert property (cmd_valid && !cmd_write |-> cmd_value_len == 8'h00)
    else $error("read carries a value length");
  a_write_len: assert property (cmd_valid && cmd_write |-> cmd_value_len != 8'h00)
    else $error("write has no value bytes");
  a_one_cmd: assert property (cmd_valid |-> !rx_ready && !event_ready)
    else $error("input open while command runs");
  a_esc_pair: assert property (escaped_mode && tx_valid && tx_ready && tx_data == 8'h7d
    |-> ##[1:4] (tx_valid && tx_data inside {8'h5e, 8'h5d, 8'h31, 8'h33}))
    else $error("escape not followed by flipped byte");
  cp_stage: cover property (cmd_valid && cmd_stage);
  cp_done: cover property (cmd_done && cmd_valid);
  cp_esc: cover property (escaped_mode && tx_valid && tx_data == 8'h7d);
  cp_more: cover property (cmd_valid && cmd_done && cmd_more);
endmodule
bind alcs_core alcs_core_chk chk (.clock(clock), .arst_n(arst_n), .escaped_mode(escaped_mode), .rx_ready(rx_ready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .event_ready(event_ready), .cmd_valid(cmd_valid),
  .cmd_write(cmd_write), .cmd_stage(cmd_stage), .cmd_name(cmd_name), .cmd_value(cmd_value),
  .cmd_value_len(cmd_value_len), .cmd_done(cmd_done), .cmd_more(cmd_more));

//--- alcs_host.sv
`timescale 1ns/1ns
// ********************
// host controller model
// ********************
module alcs_host (
  input logic clock,
  input logic escaped_mode,
  input logic rx_ready,
  input logic stall,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_ready
);
  integer seed = 50043;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  // random back-pressure on replies while stall is set
  always @(negedge clock) tx_ready <= !stall || $random(seed) % 3 != 0;
  // one byte, held until the parser takes it
  task automatic raw(input logic [7:0] b);
    @(negedge clock);
    rx_data = b;
    rx_valid = 1'b1;
    #1;
    while (rx_ready !== 1'b1) begin
      @(negedge clock);
      #1;
    end
    @(posedge clock);
  endtask
  task automatic put(input logic [7:0] b);
    if (escaped_mode && (b == 8'h7e || b == 8'h7d || b == 8'h11 || b == 8'h13)) begin
      raw(8'h7d);
      raw(b ^ 8'h20);
    end else raw(b);
  endtask
  // whole frame; bad flips the checksum low bit
  task automatic send_frame(input logic [7:0] d[$], input bit bad);
    logic [7:0] sum;
    sum = 8'h00;
    raw(8'h7e);
    put(8'h00);
    put(8'(d.size()));
    foreach (d[i]) begin
      put(d[i]);
      sum += d[i];
    end
    put((8'hff - sum) ^ {7'h0, bad});
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data = ~rx_data; // released line shows no stale byte
  endtask
endmodule

//--- alcs_core_tb.sv
`timescale 1ns/1ns
// ********************
// self-checking bench
// ********************
module alcs_core_tb;
  logic clock, arst_n, escaped_mode, rx_valid, rx_ready, tx_valid, tx_ready, watchdog_reset_seen, stall;
  logic event_valid, event_ready, cmd_valid, cmd_write, cmd_stage, cmd_done, cmd_more, ew, es;
  logic [7:0] rx_data, tx_data, event_code, cmd_value_len, cmd_status, cmd_rdata_len, evl;
  logic [15:0] cmd_name, en;
  logic [31:0] cmd_value, cmd_rdata, ev;
  logic [7:0] exp[$];
  logic [7:0] fd[$];
  logic [7:0] codes[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h0d};
  int n_mismatch = 0, num_checks = 0, ncmd = 0, cyc = 0, rd_len = 0, n_more = 0;
  alcs_core dut (.clock(clock), .arst_n(arst_n), .escaped_mode(escaped_mode), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .watchdog_reset_seen(watchdog_reset_seen), .event_valid(event_valid), .event_code(event_code),
    .event_ready(event_ready), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_stage(cmd_stage),
    .cmd_name(cmd_name), .cmd_value(cmd_value), .cmd_value_len(cmd_value_len), .cmd_done(cmd_done),
    .cmd_status(cmd_status), .cmd_rdata(cmd_rdata), .cmd_rdata_len(cmd_rdata_len), .cmd_more(cmd_more));
  alcs_host host (.clock(clock), .escaped_mode(escaped_mode), .rx_ready(rx_ready), .stall(stall),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic push(input logic [7:0] b);
    if (escaped_mode && (b == 8'h7e || b == 8'h7d || b == 8'h11 || b == 8'h13)) begin
      exp.push_back(8'h7d);
      exp.push_back(b ^ 8'h20);
    end else exp.push_back(b);
  endtask
  // expected reply bytes for the frame data in fd
  task automatic expect_frame();
    logic [7:0] sum;
    sum = 8'h00;
    exp.push_back(8'h7e);
    push(8'h00);
    push(8'(fd.size()));
    foreach (fd[i]) begin
      push(fd[i]);
      sum += fd[i];
    end
    push(8'hff - sum);
  endtask
  task automatic settle();
    while (exp.size() != 0 || cmd_valid === 1'b1) @(negedge clock);
    repeat (40) @(negedge clock); // room for any stray reply byte
  endtask
  // one command frame plus its expected reply; id zero expects none
  task automatic cmd(input logic [7:0] t, input logic [7:0] id, input logic [15:0] nm, input int vl, input int rl);
    ev = $random(host.seed);
    ev = vl == 4 ? ev : ev & ((32'h1 << (8 * vl)) - 32'h1);
    ew = vl != 0;
    es = ew && t == 8'h09;
    en = nm;
    evl = 8'(vl);
    cmd_rdata = $random(host.seed);
    rd_len = rl;
    // in a multi-answer read all but the last reply carry data; the last is an empty ok
    for (int k = 0; k <= n_more && id != 8'h00; k++) begin
      fd = '{8'h88, id, nm[15:8], nm[7:0], cmd_status};
      if (k < n_more || n_more == 0)
        for (int i = rl - 1; i >= 0; i--) fd.push_back(cmd_rdata[8 * i +: 8]);
      expect_frame();
    end
    fd = '{t, id, nm[15:8], nm[7:0]};
    for (int i = vl - 1; i >= 0; i--) fd.push_back(ev[8 * i +: 8]);
    host.send_frame(fd, 1'b0);
    settle();
  endtask
  task automatic event_frame(input logic [7:0] c);
    fd = '{8'h8a, c};
    expect_frame();
    @(negedge clock);
    event_valid = 1'b1;
    event_code = c;
    #1;
    while (event_ready !== 1'b1) begin
      @(negedge clock);
      #1;
    end
    @(negedge clock);
    event_valid = 1'b0;
    settle();
  endtask
  // reply watcher: every accepted byte takes the oldest note
  always @(posedge clock)
    if ($sampled(arst_n && tx_valid && tx_ready)) begin
      if (exp.size() == 0)
        chk("unexpected tx byte", 64'h100, $sampled(tx_data));
      else
        chk("tx byte", exp.pop_front(), $sampled(tx_data));
    end
  // parameter store stand-in; a further answer waits until the reply before it has gone out
  initial begin
    cmd_done = 1'b0;
    cmd_more = 1'b0;
    cmd_rdata_len = 8'h00;
    forever begin
      @(negedge clock);
      if (cmd_valid === 1'b1) begin
        chk("command", {ew, es, en, ev, evl},
            {cmd_write, cmd_stage, cmd_name, cmd_write ? cmd_value : 32'h0, cmd_value_len});
        ncmd++;
        repeat (2) @(negedge clock);
        for (int k = 0; k <= n_more; k++) begin
          cmd_more = k < n_more;
          cmd_rdata_len = (k < n_more || n_more == 0) ? 8'(rd_len) : 8'h00;
          cmd_done = 1'b1;
          @(negedge clock);
          cmd_done = 1'b0;
          cmd_more = 1'b0;
          repeat (2) @(negedge clock);
          while (tx_valid === 1'b1) @(negedge clock);
        end
        while (cmd_valid === 1'b1) @(negedge clock);
      end
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    arst_n = 1'b0;
    escaped_mode = 1'b0;
    stall = 1'b0;
    watchdog_reset_seen = 1'b0;
    event_valid = 1'b0;
    event_code = 8'h00;
    cmd_status = 8'h00;
    cmd_rdata = 32'h0;
    fd = '{8'h8a, 8'h00};
    expect_frame();
    repeat (6) @(negedge clock);
    arst_n = 1'b1;
    settle();
    $display("test boot done");
    stall = 1'b1;
    cmd(8'h08, 8'h4d, 16'h444c, 4, 0);
    for (int s = 0; s < 4; s++) begin
      cmd_status = 8'(s);
      cmd(8'h09, 8'(s + 1), 16'h4244, 0, 2);
    end
    cmd_status = 8'h00;
    cmd(8'h09, 8'h05, 16'h444c, 2, 0);
    cmd(8'h08, 8'h00, 16'h444c, 1, 0);
    n_more = 2;
    cmd(8'h08, 8'h0a, 16'h4e44, 0, 4);
    n_more = 0;
    $display("test commands done");
    host.send_frame(fd, 1'b1);
    settle();
    // a foreign frame type and a frame too short for a name are dropped as well
    fd = '{8'h17, 8'h01, 8'h44, 8'h4c};
    host.send_frame(fd, 1'b0);
    fd = '{8'h08, 8'h01, 8'h44};
    host.send_frame(fd, 1'b0);
    settle();
    chk("commands run", 8, ncmd);
    $display("test bad checksum done");
    foreach (codes[i]) event_frame(codes[i]);
    $display("test events done");
    escaped_mode = 1'b1;
    cmd(8'h08, 8'h7e, 16'h444c, 4, 0);
    cmd(8'h09, 8'h7d, 16'h4244, 0, 4);
    $display("test escaped done");
    escaped_mode = 1'b0;
    arst_n = 1'b0;
    watchdog_reset_seen = 1'b1;
    fd = '{8'h8a, 8'h01};
    expect_frame();
    repeat (6) @(negedge clock);
    arst_n = 1'b1;
    settle();
    $display("test watchdog reset done");
    summarize();
  end
endmodule
